// ==== blk_enc_pkg.sv ====
// constants and carriers for the single-block encryptor with memory fetch
// assumes a word-wide memory port with a one-word request/acknowledge
package blk_enc_pkg;
    // byte offsets inside the in-place data structure
    localparam logic [5:0] OFS_KEY    = 6'h00;
    localparam logic [5:0] OFS_CLEAR  = 6'h10;
    localparam logic [5:0] OFS_CIPHER = 6'h20;
    localparam logic [5:0] STRUCT_BYTES = 6'h30;
    // word indices derived from the byte offsets
    localparam logic [3:0] KEY_WORD0    = 4'(OFS_KEY >> 2);
    localparam logic [3:0] CLEAR_LAST   = 4'((OFS_CLEAR >> 2) + 3);
    localparam logic [3:0] CIPHER_WORD0 = 4'(OFS_CIPHER >> 2);
    localparam logic [3:0] CIPHER_LAST  = 4'((OFS_CIPHER >> 2) + 3);
    localparam logic [31:0] PTR_RESET   = 32'h0000_0000;

    typedef enum {ST_IDLE, ST_FETCH, ST_ARB, ST_RUN, ST_STORE} state_t;

    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dma_cmd_t;
endpackage

// ==== blk_encrypt.sv ====
// single-block forward cipher engine: fetch, encrypt on shared core, store
// assumes an external shared cipher core with a grant from its arbiter
// and a memory port that holds each request until it is acknowledged
`timescale 1ns/1ps
module blk_encrypt #(
    parameter logic [31:0] RAM_BASE  = 32'h0000_0000,
    parameter logic [31:0] RAM_BYTES = 32'h0000_8000
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // tasks, pointer and event control
    input  wire logic                start_block_encrypt_task,
    input  wire logic                abort_encrypt_task,
    input  wire logic [31:0]         block_data_pointer,
    input  wire logic                done_int_enable,
    input  wire logic                error_int_enable,
    input  wire logic                clear_done,
    input  wire logic                clear_error,
    output logic                     encrypt_done_event,
    output logic                     encrypt_error_event,
    output logic                     irq,
    // memory master
    output logic                     dma_valid,
    output blk_enc_pkg::dma_cmd_t    dma_cmd,
    input  wire logic                dma_ack,
    input  wire logic [31:0]         dma_rdata,
    // shared cipher core
    output logic                     core_request,
    input  wire logic                core_grant,
    input  wire logic                core_other_busy,
    output logic                     core_start,
    output logic [127:0]             core_key,
    output logic [127:0]             core_text,
    input  wire logic                core_done,
    input  wire logic [127:0]        core_result
);
    // elaboration check: the window must hold one aligned structure
    if (RAM_BYTES < 32'(blk_enc_pkg::STRUCT_BYTES)
            || RAM_BASE[1:0] != 2'b00) begin : g_bad_window
        $error("ram window cannot hold an aligned data structure");
    end

    blk_enc_pkg::state_t state;
    logic [31:0]  ptr;
    logic [3:0]   word_idx;
    logic [255:0] inbuf;
    logic [127:0] outbuf;
    logic         abort_pend;

    ////////////////////////////////////////////////////////////////////////
    // decode; pointer range is checked before any access is made
    wire logic [32:0] ptr_end  = {1'b0, block_data_pointer}
                               + 33'(blk_enc_pkg::STRUCT_BYTES);
    wire logic [32:0] ram_end  = {1'b0, RAM_BASE} + {1'b0, RAM_BYTES};
    wire logic in_ram   = block_data_pointer >= RAM_BASE
                        && ptr_end <= ram_end;
    wire logic idle     = state == blk_enc_pkg::ST_IDLE;
    wire logic go       = idle && start_block_encrypt_task
                        && !core_other_busy && in_ram;
    wire logic busy_hit = start_block_encrypt_task
                        && (!idle || core_other_busy);
    wire logic bad_ptr  = idle && start_block_encrypt_task
                        && !core_other_busy && !in_ram;
    wire logic stop_now = abort_pend || abort_encrypt_task;
    wire logic xfer     = dma_valid && dma_ack;
    // a pending abort waits for the beat in flight, so memory is quiet
    wire logic mem_stop = xfer && stop_now;
    wire logic lost     = state == blk_enc_pkg::ST_RUN && !core_grant;
    wire logic run_stop = (state == blk_enc_pkg::ST_ARB
                        || state == blk_enc_pkg::ST_RUN)
                        && abort_encrypt_task;
    wire logic done_set = state == blk_enc_pkg::ST_STORE && xfer
                        && !stop_now
                        && word_idx == blk_enc_pkg::CIPHER_LAST;
    wire logic err_set  = busy_hit || bad_ptr || mem_stop || lost
                        || run_stop;

    // handshakes are combinational from state
    assign dma_valid    = state == blk_enc_pkg::ST_FETCH
                       || state == blk_enc_pkg::ST_STORE;
    // one driver for the whole command word
    assign dma_cmd = '{we:    state == blk_enc_pkg::ST_STORE,
                       addr:  ptr + {26'h0, word_idx, 2'b00},
                       wdata: outbuf[32*word_idx[1:0] +: 32]};
    // request drops the same cycle the grant is withdrawn
    assign core_request = state == blk_enc_pkg::ST_ARB
                       || (state == blk_enc_pkg::ST_RUN && core_grant);
    assign core_start   = state == blk_enc_pkg::ST_ARB && core_grant
                       && !abort_encrypt_task;
    // forward direction only, no inverse path exists
    assign core_key     = inbuf[127:0];
    assign core_text    = inbuf[255:128];
    assign irq = (encrypt_done_event && done_int_enable)
              || (encrypt_error_event && error_int_enable);

    ////////////////////////////////////////////////////////////////////////
    // operation sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= blk_enc_pkg::ST_IDLE;
            ptr        <= blk_enc_pkg::PTR_RESET;
            word_idx   <= 4'h0;
            abort_pend <= 1'b0;
        end else begin
            abort_pend <= dma_valid && !dma_ack && stop_now;
            unique case (state)
                blk_enc_pkg::ST_IDLE: begin
                    if (go) begin
                        ptr      <= block_data_pointer;
                        word_idx <= blk_enc_pkg::KEY_WORD0;
                        state    <= blk_enc_pkg::ST_FETCH;
                    end
                end
                blk_enc_pkg::ST_FETCH: begin
                    if (mem_stop)
                        state <= blk_enc_pkg::ST_IDLE;
                    else if (xfer && word_idx == blk_enc_pkg::CLEAR_LAST)
                        state <= blk_enc_pkg::ST_ARB;
                    else if (xfer)
                        word_idx <= word_idx + 4'h1;
                end
                // waits for the core as long as higher users hold it
                blk_enc_pkg::ST_ARB: begin
                    if (abort_encrypt_task)
                        state <= blk_enc_pkg::ST_IDLE;
                    else if (core_grant)
                        state <= blk_enc_pkg::ST_RUN;
                end
                blk_enc_pkg::ST_RUN: begin
                    if (lost || abort_encrypt_task)
                        state <= blk_enc_pkg::ST_IDLE;
                    else if (core_done) begin
                        word_idx <= blk_enc_pkg::CIPHER_WORD0;
                        state    <= blk_enc_pkg::ST_STORE;
                    end
                end
                blk_enc_pkg::ST_STORE: begin
                    if (mem_stop || done_set)
                        state <= blk_enc_pkg::ST_IDLE;
                    else if (xfer)
                        word_idx <= word_idx + 4'h1;
                end
            endcase
        end
    end

    // data capture; words land little-endian, key in the low half
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            inbuf  <= '0;
            outbuf <= '0;
        end else begin
            if (state == blk_enc_pkg::ST_FETCH && xfer)
                inbuf[32*word_idx[2:0] +: 32] <= dma_rdata;
            if (state == blk_enc_pkg::ST_RUN && core_grant && core_done)
                outbuf <= core_result;
        end
    end

    // sticky events; a set in the clearing cycle wins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            encrypt_done_event  <= 1'b0;
            encrypt_error_event <= 1'b0;
        end else begin
            encrypt_done_event  <= done_set
                || (encrypt_done_event && !clear_done);
            encrypt_error_event <= err_set
                || (encrypt_error_event && !clear_error);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_start_fetch;
        @(posedge ref_clk) disable iff (!rstn)
        go |=> dma_valid && !dma_cmd.we && word_idx == 4'h0
               && dma_cmd.addr == $past(block_data_pointer);
    endproperty
    a_start_fetch: assert property (p_start_fetch)
        else $error("start did not begin with key fetch");

    property p_done_after_store;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(encrypt_done_event) |-> $past(xfer) && $past(dma_cmd.we)
            && $past(word_idx) == 4'hB && !dma_valid;
    endproperty
    a_done_after_store: assert property (p_done_after_store)
        else $error("done raised before last ciphertext word");

    property p_run_abort;
        @(posedge ref_clk) disable iff (!rstn)
        run_stop |=> idle && encrypt_error_event && !core_request;
    endproperty
    a_run_abort: assert property (p_run_abort)
        else $error("abort did not halt with error");

    property p_grant_lost;
        @(posedge ref_clk) disable iff (!rstn)
        state == blk_enc_pkg::ST_RUN && !core_grant
            |-> !core_request ##1 (idle && encrypt_error_event);
    endproperty
    a_grant_lost: assert property (p_grant_lost)
        else $error("lost core without release and error");

    property p_ram_only;
        @(posedge ref_clk) disable iff (!rstn)
        dma_valid |-> dma_cmd.addr >= RAM_BASE
            && {1'b0, dma_cmd.addr} + 33'h4 <= ram_end;
    endproperty
    a_ram_only: assert property (p_ram_only)
        else $error("memory access outside data ram");

    property p_quiet_on_error;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(encrypt_error_event) && !$past(busy_hit)
            |-> !dma_valid ##1 !dma_valid;
    endproperty
    a_quiet_on_error: assert property (p_quiet_on_error)
        else $error("memory still busy after error event");

    property p_store_place;
        @(posedge ref_clk) disable iff (!rstn)
        dma_valid && dma_cmd.we |-> dma_cmd.addr - ptr >= 32'h20
            && dma_cmd.addr - ptr <= 32'h2C;
    endproperty
    a_store_place: assert property (p_store_place)
        else $error("ciphertext written outside its slot");

    property p_busy_start;
        @(posedge ref_clk) disable iff (!rstn)
        idle && start_block_encrypt_task && core_other_busy
            |=> idle && encrypt_error_event && !dma_valid;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("start on busy core not refused");

    property p_sticky_irq;
        @(posedge ref_clk) disable iff (!rstn)
        encrypt_done_event && !clear_done && done_int_enable
            |=> encrypt_done_event && (irq || !done_int_enable);
    endproperty
    a_sticky_irq: assert property (p_sticky_irq)
        else $error("done event or interrupt dropped");

    c_full_op: cover property (@(posedge ref_clk) disable iff (!rstn)
        done_set);
    c_lost_core: cover property (@(posedge ref_clk) disable iff (!rstn)
        lost);
    c_abort_mem: cover property (@(posedge ref_clk) disable iff (!rstn)
        mem_stop);
    c_busy_start: cover property (@(posedge ref_clk) disable iff (!rstn)
        busy_hit);
endmodule // blk_encrypt

// ==== blk_mem_core_model.sv ====
// memory and shared cipher core model facing the block encryptor
// assumes a 256-byte RAM window and a one-beat request/acknowledge
`timescale 1ns/1ps
module blk_mem_core_model #(
    parameter logic [127:0] MIX = 128'h0
) (
    // bench control
    input  wire logic                  ref_clk,
    input  wire logic                  slow,
    input  wire logic                  preempt,
    // memory side
    input  wire logic                  dma_valid,
    input  wire blk_enc_pkg::dma_cmd_t dma_cmd,
    output logic                       dma_ack,
    output logic [31:0]                dma_rdata,
    // core side
    input  wire logic                  core_request,
    input  wire logic                  core_start,
    input  wire logic [127:0]          core_key,
    input  wire logic [127:0]          core_text,
    output logic                       core_grant,
    output logic                       core_done,
    output logic [127:0]               core_result
);
    logic [31:0] mem [0:63];
    logic [1:0]  stall;
    logic [2:0]  run;
    wire  [5:0]  idx = dma_cmd.addr[7:2];
    wire         ready = !slow || (stall == 2'h3);
    initial begin
        {dma_ack, dma_rdata, core_grant, stall, run} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // slow mode stalls each beat; idle read data toggles, never holds
    always @(posedge ref_clk) begin
        if (dma_valid && !dma_ack && ready) begin
            dma_ack   <= 1'h1;
            dma_rdata <= mem[idx];
            stall     <= 2'h0;
            if (dma_cmd.we) begin
                mem[idx] <= dma_cmd.wdata;
            end
        end else begin
            dma_ack   <= 1'h0;
            dma_rdata <= ~dma_rdata;
            stall     <= stall + {1'h0, dma_valid && !dma_ack};
        end
    end
    // grant registered to avoid a loop through the request
    always @(posedge ref_clk) begin
        core_grant <= core_request && !preempt;
        if (core_start) begin
            run <= 3'h1;
        end else begin
            run <= (run == 3'h0 || run == 3'h4) ? 3'h0 : run + 3'h1;
        end
    end
    // stand-in cipher: result differs from both key and text
    assign core_done   = (run == 3'h4) && core_grant;
    assign core_result = core_key ^ core_text ^ MIX;
endmodule // blk_mem_core_model

// ==== blk_encrypt_tb.sv ====
// self-checking bench for the single-block encryptor
// assumes the model stands in for data RAM and the shared core
`timescale 1ns/1ps
module blk_encrypt_tb;
    localparam logic [127:0] MIX = 128'hC3A5_9617_0E4D_B28F_71E6_5A3C_D094_2B7E;
    logic ref_clk = 1'h0, rstn = 1'h0, slow = 1'h0, preempt = 1'h0;
    logic start_block_encrypt_task = 1'h0, abort_encrypt_task = 1'h0;
    logic [31:0] block_data_pointer = 32'h0;
    logic done_int_enable = 1'h1, error_int_enable = 1'h0;
    logic clear_done = 1'h0, clear_error = 1'h0, core_other_busy = 1'h0;
    logic encrypt_done_event, encrypt_error_event, irq, dma_valid, dma_ack;
    logic core_request, core_grant, core_start, core_done;
    logic [31:0] dma_rdata;
    logic [127:0] core_key, core_text, core_result;
    blk_enc_pkg::dma_cmd_t dma_cmd;
    int num_errors = 0, checks_done = 0, beats = 0;

    blk_encrypt #(.RAM_BYTES(32'h0000_0100)) blk_encrypt_i (.ref_clk, .rstn,
        .start_block_encrypt_task, .abort_encrypt_task, .block_data_pointer,
        .done_int_enable, .error_int_enable, .clear_done, .clear_error,
        .encrypt_done_event, .encrypt_error_event, .irq, .dma_valid, .dma_cmd,
        .dma_ack, .dma_rdata, .core_request, .core_grant, .core_other_busy,
        .core_start, .core_key, .core_text, .core_done, .core_result);
    blk_mem_core_model #(.MIX(MIX)) blk_mem_core_model_i (.ref_clk, .slow,
        .preempt, .dma_valid, .dma_cmd, .dma_ack, .dma_rdata, .core_request,
        .core_start, .core_key, .core_text, .core_grant, .core_done,
        .core_result);

    ////////////////////////////////////////////////////////////////////////
    // clock and completed memory beats
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (dma_valid && dma_ack) begin
            beats <= beats + 1;
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [31:0] pat(input logic [31:0] p, input int i);
        return 32'hA5C3_0000 ^ (p << 8) ^ 32'(i * 32'h0101_0101);
    endfunction
    // both clears together; sticky events must then read low
    task automatic clear_events();
        @(negedge ref_clk);
        {clear_done, clear_error} = 2'h3;
        @(negedge ref_clk);
        {clear_done, clear_error} = 2'h0;
        check("cleared", {encrypt_done_event, encrypt_error_event, irq}, 0);
    endtask
    // mode 0 plain, 1 abort in fetch, 2 core taken away, 3 double start,
    // 4 abort while the core runs
    task automatic op(input logic [31:0] ptr, input int mode);
        logic ed, ee;
        int n;
        n = 0;
        ed = (mode == 0 || mode == 3);
        ee = (mode != 0);
        for (int i = 0; i < 8; i++) begin
            blk_mem_core_model_i.mem[ptr[7:2] + i] = pat(ptr, i);
        end
        @(negedge ref_clk);
        block_data_pointer = ptr;
        error_int_enable = (mode == 2);
        start_block_encrypt_task = 1'h1;
        repeat (mode == 3 ? 2 : 1) @(negedge ref_clk);
        start_block_encrypt_task = 1'h0;
        if (mode == 1) begin
            repeat (3) @(negedge ref_clk);
            abort_encrypt_task = 1'h1;
            @(negedge ref_clk);
            abort_encrypt_task = 1'h0;
        end
        while ((mode == 2 || mode == 4) && !core_start && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (mode == 4) begin
            @(negedge ref_clk);
            abort_encrypt_task = 1'h1;
            @(negedge ref_clk);
            abort_encrypt_task = 1'h0;
        end
        if (mode == 2) begin
            preempt = 1'h1;
            @(negedge ref_clk);
            check("core released", 32'(core_request), 0);
            preempt = 1'h0;
        end
        while (!(ed ? encrypt_done_event : encrypt_error_event) && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (2) @(negedge ref_clk);
        check("events", {encrypt_done_event, encrypt_error_event}, {ed, ee});
        check("dma idle", 32'(dma_valid), 0);
        check("irq", 32'(irq), 32'(ed | (ee & mode == 2)));
        for (int k = 0; k < 4 && ed; k++) begin
            check("cipher", blk_mem_core_model_i.mem[ptr[7:2] + 8 + k], pat(ptr, k) ^ pat(ptr, k + 4) ^ MIX[32 * k +: 32]);
        end
        clear_events();
        $display("op mode %0d at %h ended", mode, ptr);
    endtask
    // start that must be refused at once, with no memory traffic
    task automatic refuse(input logic [31:0] ptr, input logic busy);
        int b;
        b = beats;
        @(negedge ref_clk);
        block_data_pointer = ptr;
        {error_int_enable, core_other_busy} = {1'h1, busy};
        start_block_encrypt_task = 1'h1;
        @(negedge ref_clk);
        {start_block_encrypt_task, core_other_busy} = 2'h0;
        repeat (3) @(negedge ref_clk);
        check("refused", {encrypt_done_event, encrypt_error_event, irq}, 3);
        check("no beats", 32'(beats - b), 0);
        clear_events();
        $display("refusal at %h ended", ptr);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge ref_clk);
        check("reset", {encrypt_done_event, encrypt_error_event, irq, dma_valid, core_request}, 0);
        rstn = 1'h1;
        op(32'h40, 0);
        slow = 1'h1;
        op(32'h80, 0);
        op(32'h00, 3);
        op(32'h40, 1);
        slow = 1'h0;
        op(32'h80, 2);
        op(32'h40, 4);
        op(32'hD0, 0);
        refuse(32'hD4, 1'h0);
        refuse(32'h40, 1'h1);
        stop_test();
    end
    // hang guard, far beyond the few hundred cycles the whole run of ops needs
    initial begin
        #100000;
        num_errors++;
        stop_test();
    end
endmodule // blk_encrypt_tb
